/* File: rtl/pc_stack_pkg.sv */
package pc_stack_pkg;
    localparam int PC_WIDTH = 13;
    localparam int LOW_WIDTH = 8;
    localparam int LATCH_WIDTH = 5;
    localparam int JUMP_FIELD_WIDTH = 11;
    localparam int STACK_DEPTH = 8;
    localparam int PTR_WIDTH = 3;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [12:0] VECTOR_DEFAULT = 13'h0004;
    localparam logic [12:0] PC_STEP = 13'h0001;
    localparam logic [2:0] PTR_STEP = 3'h1;
    localparam logic [2:0] PTR_RESET = 3'h0;
endpackage

/* File: rtl/program_counter_and_call_stack.sv */
// Operation
// - A 13-bit program counter addresses instruction memory.
// - The low eight counter bits form a readable and writable register.
// - Upper counter bits are never read back; low-byte writes take them from the latch, calls and jumps take only bits 12..11 from it.
// - Any reset clears the upper counter bits.
// - Writing the low byte copies latch bits 4..0 into counter bits 12..8.
// - Call or jump loads counter bits 12..11 from latch bits 4..3.
// - Call or jump takes counter bits 10..0 from the instruction field.
// - Return stack is eight entries of 13 bits.
// - Stack and its pointer are not reachable by software.
// - Calls and interrupt vectoring push the counter.
// - Return, return-with-literal and return-from-interrupt pop the stack.
// - A pop restores all 13 bits, ignoring the latch.
// - Push and pop leave the high holding latch unchanged.
// - The stack is circular; the ninth push overwrites the first.
// - No overflow or underflow flag exists.
`timescale 1ns/1ps
`default_nettype none
module program_counter_and_call_stack #(
    parameter logic [12:0] VECTOR_ADDR = pc_stack_pkg::VECTOR_DEFAULT
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic advance_i,
    input wire logic low_byte_write_i,
    input wire logic [7:0] low_byte_data_i,
    input wire logic latch_write_i,
    input wire logic [4:0] latch_data_i,
    input wire logic call_i,
    input wire logic jump_i,
    input wire logic [10:0] jump_field_i,
    input wire logic interrupt_vector_i,
    input wire logic return_i,
    input wire logic return_with_literal_i,
    input wire logic return_from_interrupt_i,
    output logic [12:0] pc_o,
    output logic [7:0] pc_low_byte_reg_o,
    output logic [4:0] pc_high_holding_latch_o
);
    localparam int LW = pc_stack_pkg::LOW_WIDTH;
    localparam int JW = pc_stack_pkg::JUMP_FIELD_WIDTH;
    localparam int PW = pc_stack_pkg::PC_WIDTH;

    initial begin
        if (PW != LW + pc_stack_pkg::LATCH_WIDTH || (1 << pc_stack_pkg::PTR_WIDTH) != pc_stack_pkg::STACK_DEPTH) begin
            $error("Inconsistent program counter or stack geometry");
        end
        // A call or jump supplies the field and the two page bits, nothing else
        if (JW + 2 != PW) begin
            $error("Jump field and page bits do not cover the counter");
        end
    end

    logic [12:0] pc;
    logic [4:0] pc_high_holding_latch;
    // stack storage, no software path to it or the pointer
    logic [12:0] stack_mem [pc_stack_pkg::STACK_DEPTH];
    logic [2:0] stack_ptr;
    logic [12:0] next_pc;
    logic do_push;
    logic do_pop;
    logic [2:0] pop_ptr;

    assign do_push = call_i || interrupt_vector_i;
    assign do_pop = return_i || return_with_literal_i || return_from_interrupt_i;
    assign pop_ptr = stack_ptr - pc_stack_pkg::PTR_STEP;

    // Priority: interrupt, return, call/jump, low-byte write, increment
    always_comb begin
        next_pc = pc;
        if (interrupt_vector_i) begin
            next_pc = VECTOR_ADDR;
        end else if (do_pop) begin
            next_pc = stack_mem[pop_ptr];
        end else if (call_i || jump_i) begin
            next_pc = {pc_high_holding_latch[4:3], jump_field_i};
        end else if (low_byte_write_i) begin
            next_pc = {pc_high_holding_latch, low_byte_data_i};
        end else if (advance_i) begin
            next_pc = pc + pc_stack_pkg::PC_STEP;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc <= pc_stack_pkg::PC_RESET;
        end else begin
            pc <= next_pc;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_high_holding_latch <= '0;
        end else if (latch_write_i) begin
            pc_high_holding_latch <= latch_data_i;
        end
    end

    // a call saves the return address, the interrupt the interrupted one
    // pointer wraps, overwriting oldest; no flags kept
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stack_ptr <= pc_stack_pkg::PTR_RESET;
        end else if (do_push) begin
            stack_ptr <= stack_ptr + pc_stack_pkg::PTR_STEP;
        end else if (do_pop) begin
            stack_ptr <= pop_ptr;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (do_push) begin
            stack_mem[stack_ptr] <= call_i && !interrupt_vector_i ? pc + pc_stack_pkg::PC_STEP : pc;
        end
    end

    // software sees only the low byte and the latch; pc_o carries the full counter
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_o <= pc_stack_pkg::PC_RESET;
            pc_low_byte_reg_o <= '0;
            pc_high_holding_latch_o <= '0;
        end else begin
            pc_o <= next_pc;
            pc_low_byte_reg_o <= next_pc[7:0];
            pc_high_holding_latch_o <= latch_write_i ? latch_data_i : pc_high_holding_latch;
        end
    end

    a_reset_upper: assert property (@(posedge core_clk_i) $rose(rst_n_i) |-> pc[12:8] == '0)
        else $error("Upper counter bits not cleared by reset");
    a_low_write_load: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        low_byte_write_i && !interrupt_vector_i && !do_pop && !call_i && !jump_i
        |=> pc == {$past(pc_high_holding_latch), $past(low_byte_data_i)})
        else $error("Low byte write did not load latch into upper bits");
    a_jump_page: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (call_i || jump_i) && !interrupt_vector_i && !do_pop
        |=> pc[12:11] == $past(pc_high_holding_latch[4:3]) && pc[10:0] == $past(jump_field_i))
        else $error("Call or jump target wrong");
    a_call_return: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        call_i && !interrupt_vector_i ##1 (return_i && !interrupt_vector_i && !do_push)
        |=> pc == $past(pc, 2) + pc_stack_pkg::PC_STEP)
        else $error("Return did not restore the call address");
    a_latch_stable: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (do_push || do_pop) && !latch_write_i |=> $stable(pc_high_holding_latch))
        else $error("Stack operation changed the latch");
    a_ptr_wrap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        do_push |=> stack_ptr == $past(stack_ptr) + pc_stack_pkg::PTR_STEP)
        else $error("Stack pointer did not advance circularly");
    a_pop_ptr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        do_pop && !do_push |=> stack_ptr == $past(pop_ptr))
        else $error("Pop did not move the pointer back");
    a_increment: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        advance_i && !interrupt_vector_i && !do_pop && !call_i && !jump_i && !low_byte_write_i
        |=> pc == $past(pc) + pc_stack_pkg::PC_STEP)
        else $error("Counter did not increment");
    a_vector: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        interrupt_vector_i |=> pc == VECTOR_ADDR)
        else $error("Interrupt did not branch to the vector");

    // Outputs lag nothing: counter outputs load from the counter's next value, the latch output from the latch's next value
    a_out_mirror: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pc_o == pc)
        else $error("Counter output differs from the counter");
    a_low_byte_out: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pc_low_byte_reg_o == pc[7:0])
        else $error("Low byte output differs from the counter");
    a_latch_out: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pc_high_holding_latch_o == pc_high_holding_latch)
        else $error("Latch output differs from the latch");

    // Stack contents after a push, checked apart from any later return
    a_call_push: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        call_i && !interrupt_vector_i
        |=> stack_mem[$past(stack_ptr)] == $past(pc) + pc_stack_pkg::PC_STEP)
        else $error("Call did not save the return address");
    a_int_push: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        interrupt_vector_i |=> stack_mem[$past(stack_ptr)] == $past(pc))
        else $error("Interrupt did not save the interrupted address");

    // Every pop kind restores the entry below the pointer, whatever the latch holds
    a_pop_restore: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        do_pop && !interrupt_vector_i && !do_push
        |=> pc == $past(stack_mem[pop_ptr]))
        else $error("Pop did not restore the saved address");
    a_hold_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !advance_i && !low_byte_write_i && !call_i && !jump_i && !interrupt_vector_i && !do_pop
        |=> pc == $past(pc))
        else $error("Counter moved without a request");
    a_latch_load: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        latch_write_i |=> pc_high_holding_latch == $past(latch_data_i))
        else $error("Latch write did not take");

    c_call_ret: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) call_i ##[1:5] return_i);
    c_stack_wrap: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) do_push && stack_ptr == 3'h7);
    c_int_return_from_interrupt: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        interrupt_vector_i ##[1:10] return_from_interrupt_i);
    c_computed: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) low_byte_write_i && latch_write_i);
    c_ret_literal: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        call_i ##1 return_with_literal_i);
endmodule
`default_nettype wire

/* File: tb/instr_decoder_model.sv */
`timescale 1ns/1ps
`default_nettype none
module instr_decoder_model (
    input wire logic en_i,
    input wire logic [2:0] op_i,
    output logic [7:0] strobe_o
);
    assign strobe_o = en_i ? (8'h01 << op_i) : 8'h00;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic en = 1'b0;
    logic lw = 1'b0;
    logic [2:0] op = 3'h0;
    logic [10:0] fld = 11'h000;
    logic [7:0] dat = 8'h00;
    logic [4:0] ld = 5'h00;
    logic [7:0] st;
    logic [12:0] pc_o;
    logic [7:0] low_o;
    logic [4:0] lat_o;
    logic [12:0] pc = 13'h0000;
    logic [12:0] stk [8];
    logic [4:0] lat = 5'h00;
    logic [2:0] sp = 3'h0;
    logic [25:0] q [$];
    logic [25:0] due [$];
    int n_fail = 0;
    int cmp_count = 0;
    always #4 core_clk_i = ~core_clk_i;
    instr_decoder_model i_dec (.en_i(en), .op_i(op), .strobe_o(st));
    program_counter_and_call_stack i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .advance_i(st[0]),
        .low_byte_write_i(st[1]), .low_byte_data_i(dat), .latch_write_i(lw), .latch_data_i(ld), .call_i(st[2]),
        .jump_i(st[3]), .jump_field_i(fld), .interrupt_vector_i(st[4]), .return_i(st[5]),
        .return_with_literal_i(st[6]), .return_from_interrupt_i(st[7]), .pc_o(pc_o),
        .pc_low_byte_reg_o(low_o), .pc_high_holding_latch_o(lat_o));
    task automatic check(input logic [25:0] seen, input logic [25:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t outputs %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic issue(input logic e, input logic [2:0] o, input logic w, input logic [4:0] d5,
                         input logic [7:0] d8, input logic [10:0] f);
        @(posedge core_clk_i);
        en <= e;
        op <= o;
        lw <= w;
        ld <= d5;
        dat <= d8;
        fld <= f;
        if (e) begin
            case (o)
                3'h0: pc = pc + 13'h0001;
                3'h1: pc = {lat, d8};
                3'h2: begin
                    stk[sp] = pc + 13'h0001;
                    sp++;
                    pc = {lat[4:3], f};
                end
                3'h3: pc = {lat[4:3], f};
                3'h4: begin
                    stk[sp] = pc;
                    sp++;
                    pc = pc_stack_pkg::VECTOR_DEFAULT;
                end
                default: begin
                    sp--;
                    pc = stk[sp];
                end
            endcase
        end
        if (w) lat = d5;
        q.push_back({pc, pc[7:0], lat});
    endtask
    always @(posedge core_clk_i) begin
        #1;
        while (due.size() != 0) check({pc_o, low_o, lat_o}, due.pop_front());
        due = q;
        q = {};
    end
    task automatic done(input string name);
        issue(1'b0, 3'h0, 1'b0, 5'h00, 8'h00, 11'h000);
        $display("test %s finished", name);
    endtask
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
    initial begin
        void'($urandom(2));
        repeat (6) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        done("reset");
        issue(1'b0, 3'h0, 1'b1, 5'h19, 8'h00, 11'h000);
        issue(1'b1, 3'h1, 1'b0, 5'h00, 8'h20, 11'h000);
        issue(1'b1, 3'h0, 1'b0, 5'h00, 8'h00, 11'h000);
        issue(1'b1, 3'h2, 1'b1, 5'h02, 8'h00, 11'h005);
        issue(1'b1, 3'h6, 1'b0, 5'h00, 8'h00, 11'h000);
        issue(1'b1, 3'h3, 1'b0, 5'h00, 8'h00, 11'h7ff);
        issue(1'b1, 3'h4, 1'b0, 5'h00, 8'h00, 11'h000);
        issue(1'b1, 3'h7, 1'b0, 5'h00, 8'h00, 11'h000);
        done("load_and_stack");
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        #1;
        check({pc_o, low_o, lat_o}, 26'h0000000);
        pc = 13'h0000;
        lat = 5'h00;
        sp = 3'h0;
        @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        issue(1'b0, 3'h0, 1'b1, 5'h1f, 8'h00, 11'h000);
        issue(1'b1, 3'h1, 1'b0, 5'h00, 8'hff, 11'h000);
        issue(1'b1, 3'h0, 1'b0, 5'h00, 8'h00, 11'h000);
        done("reset_and_wrap");
        for (int i = 0; i < 10; i++) issue(1'b1, 3'h2, 1'b0, 5'h00, 8'h00, 11'(i));
        for (int i = 0; i < 10; i++) issue(1'b1, 3'h5, 1'b0, 5'h00, 8'h00, 11'h000);
        done("circular");
        for (int i = 0; i < 60; i++) issue(1'($urandom), 3'($urandom % 5), 1'($urandom), 5'($urandom), 8'($urandom),
                                           11'($urandom));
        done("random");
        repeat (2) @(posedge core_clk_i);
        finish_test();
    end
endmodule
`default_nettype wire
